// ==== include/gpio_pkg.sv ====
// register map, reset values and field constants of the dual gpio port block
`default_nettype none
package gpio_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PORT_W = 8;
  localparam int IDX_W = 6;
  localparam int BUS_W = 32;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_A_GATE = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_B_GATE = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_A_DATA = 6'h10;
  localparam logic [IDX_W-1:0] IDX_A_DIR = 6'h11;
  localparam logic [IDX_W-1:0] IDX_A_PULL = 6'h12;
  localparam logic [IDX_W-1:0] IDX_B_DATA = 6'h14;
  localparam logic [IDX_W-1:0] IDX_B_DIR = 6'h15;
  localparam logic [IDX_W-1:0] IDX_B_PULL = 6'h16;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PORT_W-1:0] A_GATE_RST = 8'hf9;
  localparam logic [PORT_W-1:0] B_GATE_RST = 8'hff;
  localparam logic [PORT_W-1:0] DATA_RST = 8'h00;
  localparam logic [PORT_W-1:0] DIR_RST = 8'h00;
  localparam logic [PORT_W-1:0] PULL_RST = 8'h00;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  // reserved gate bits 2..1 of port a are not stored
  localparam logic [PORT_W-1:0] A_GATE_MASK = 8'hf9;
  localparam logic [PORT_W-1:0] B_GATE_MASK = 8'hff;
  // open-drain line of port a
  localparam int A_OD_LINE = 5;
  // lines whose gated level feeds the pin interrupt logic
  localparam int A_IRQ_LINE_0 = 0;
  localparam int A_IRQ_LINE_4 = 4;
  localparam int B_IRQ_LINE_0 = 0;
  localparam int B_IRQ_LINE_5 = 5;
  localparam int IRQ_N = 4;

endpackage
`default_nettype wire

// ==== hw/sync2.sv ====
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;

  sync_s s_r;
  sync_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = async_i;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_o = s_r.stable;

endmodule
`default_nettype wire

// ==== hw/dual_port_gpio_block.sv ====
// two eight-bit gpio ports behind a classic wishbone slave
//
// Functional notes
// (RULE_01) port a gate bits 7 and 6 enable input and wake of lines 7, 6
// (RULE_02) software clears port a gate bits 7, 6 when a crystal uses them
// (RULE_03) port a gate bit 5 enables input and wake of line 5
// (RULE_04) port a gate bit 4 gates input, wake and interrupt of line 4
// (RULE_05) port a gate bit 3 enables input and wake of line 3
// (RULE_06) software writes zero to reserved port a gate bits 2 to 1
// (RULE_07) port a gate bit 0 gates input, wake and interrupt of line 0
// (RULE_08) port b gate bits 7 and 6 enable input and wake, reset ones
// (RULE_09) port b gate bit 5 gates input, wake and interrupt of line 5
// (RULE_10) port b gate bits 4 to 1 enable input and wake, reset ones
// (RULE_11) port b gate bit 0 gates input, wake and interrupt of line 0
// (RULE_12) software clears gate bits of lines used as comparator inputs
// (RULE_13) port a data register, eight bits, read/write, resets to zero
// (RULE_14) port a direction bit: 0 input, 1 output, resets to input
// (RULE_15) port a line 5 is open drain, never drives high
// (RULE_16) port a pull-up bit acts only while the line is input
// (RULE_17) port b data register, eight bits, read/write, resets to zero
// (RULE_18) port b direction bit: 0 input, 1 output, resets to input
// (RULE_19) port b pull-up bit acts only for inputs, resets disabled
// (RULE_20) output lines drive data register; input lines read synced pin
// (RULE_21) gated line presents constant zero to input, wake and interrupt
//
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module dual_port_gpio_block
  import gpio_pkg::*;
#(
  parameter int ADR_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [BUS_W-1:0] dat_i,
  output logic [BUS_W-1:0] dat_o,
  output logic ack_o,
  // port a pins
  input wire logic [PORT_W-1:0] port_a_in_i,
  output logic [PORT_W-1:0] port_a_out_o,
  output logic [PORT_W-1:0] port_a_oe_n_o,
  output logic [PORT_W-1:0] port_a_pull_o,
  // port b pins
  input wire logic [PORT_W-1:0] port_b_in_i,
  output logic [PORT_W-1:0] port_b_out_o,
  output logic [PORT_W-1:0] port_b_oe_n_o,
  output logic [PORT_W-1:0] port_b_pull_o,
  // gated inputs towards wake and interrupt logic
  output logic [PORT_W-1:0] port_a_gated_o,
  output logic [PORT_W-1:0] port_b_gated_o,
  output logic [IRQ_N-1:0] pin_irq_lvl_o,
  output logic wake_o
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADR_W < IDX_W + 2) begin : g_bad_adr
    $error("ADR_W too small for the register map");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [BUS_W-1:0] rdat;
    logic [PORT_W-1:0] a_gate;
    logic [PORT_W-1:0] b_gate;
    logic [PORT_W-1:0] a_data;
    logic [PORT_W-1:0] a_dir;
    logic [PORT_W-1:0] a_pu;
    logic [PORT_W-1:0] b_data;
    logic [PORT_W-1:0] b_dir;
    logic [PORT_W-1:0] b_pu;
    logic [PORT_W-1:0] a_out;
    logic [PORT_W-1:0] a_oe_n;
    logic [PORT_W-1:0] b_out;
    logic [PORT_W-1:0] b_oe_n;
    logic [PORT_W-1:0] a_pull;
    logic [PORT_W-1:0] b_pull;
    logic [PORT_W-1:0] a_raw;
    logic [PORT_W-1:0] b_raw;
    logic [PORT_W-1:0] a_in;
    logic [PORT_W-1:0] b_in;
    logic [IRQ_N-1:0] irq;
    logic wake;
  } gpio_s;

  gpio_s s_r;
  gpio_s s_nxt;

  logic [PORT_W-1:0] a_sync;
  logic [PORT_W-1:0] b_sync;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  sync2 #(
    .W(2 * PORT_W)
  ) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i({port_b_in_i, port_a_in_i}),
    .sync_o({b_sync, a_sync})
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic req;
  logic wr;
  logic [IDX_W-1:0] idx;
  logic [PORT_W-1:0] wbyte;
  logic [PORT_W-1:0] a_gated;
  logic [PORT_W-1:0] b_gated;
  logic [PORT_W-1:0] a_rd;
  logic [PORT_W-1:0] b_rd;
  logic [PORT_W-1:0] rbyte;

  always_comb begin
    s_nxt = s_r;
    // one wait state: ack rises the cycle after the request appears
    req = cyc_i && stb_i && !s_r.ack;
    wr = req && we_i && sel_i[0];
    idx = adr_i[IDX_W+1:2];
    wbyte = dat_i[PORT_W-1:0];

    // gated inputs; a cleared gate bit forces zero
    a_gated = a_sync & s_r.a_gate; // [RULE_01] [RULE_03] [RULE_05] [RULE_21]
    b_gated = b_sync & s_r.b_gate; // [RULE_08] [RULE_10] [RULE_21]

    // input lines read the pin, output lines the data register
    a_rd = (s_r.a_data & s_r.a_dir) | (a_gated & ~s_r.a_dir); // [RULE_20]
    b_rd = (s_r.b_data & s_r.b_dir) | (b_gated & ~s_r.b_dir); // [RULE_20]

    // gate registers are write-only and read as zero
    case (idx)
      IDX_A_DATA: rbyte = a_rd;
      IDX_A_DIR: rbyte = s_r.a_dir;
      IDX_A_PULL: rbyte = s_r.a_pu;
      IDX_B_DATA: rbyte = b_rd;
      IDX_B_DIR: rbyte = s_r.b_dir;
      IDX_B_PULL: rbyte = s_r.b_pu;
      default: rbyte = '0;
    endcase

    s_nxt.ack = req;
    s_nxt.rdat = req ? {{(BUS_W-PORT_W){1'b0}}, rbyte} : '0;

    if (wr) begin
      case (idx)
        IDX_A_GATE: s_nxt.a_gate = wbyte & A_GATE_MASK;
        IDX_B_GATE: s_nxt.b_gate = wbyte & B_GATE_MASK;
        IDX_A_DATA: s_nxt.a_data = wbyte; // [RULE_13]
        IDX_A_DIR: s_nxt.a_dir = wbyte; // [RULE_14]
        IDX_A_PULL: s_nxt.a_pu = wbyte;
        IDX_B_DATA: s_nxt.b_data = wbyte; // [RULE_17]
        IDX_B_DIR: s_nxt.b_dir = wbyte; // [RULE_18]
        IDX_B_PULL: s_nxt.b_pu = wbyte;
        default: ;
      endcase
    end

    // pin drivers; oe_n low while the line is driven
    s_nxt.a_out = s_r.a_data;
    s_nxt.a_oe_n = ~s_r.a_dir;
    s_nxt.b_out = s_r.b_data;
    s_nxt.b_oe_n = ~s_r.b_dir; // [RULE_18]
    // open drain: drive only while the line should be low
    s_nxt.a_out[A_OD_LINE] = 1'b0; // [RULE_15]
    s_nxt.a_oe_n[A_OD_LINE] = !(s_r.a_dir[A_OD_LINE] && !s_r.a_data[A_OD_LINE]); // [RULE_15]

    // pull-ups only for input lines
    s_nxt.a_pull = s_r.a_pu & ~s_r.a_dir; // [RULE_16]
    s_nxt.b_pull = s_r.b_pu & ~s_r.b_dir; // [RULE_19]

    // raw history used for wake; comparing ungated levels keeps a gate write
    // itself from looking like a pin toggle
    s_nxt.a_raw = a_sync;
    s_nxt.b_raw = b_sync;
    s_nxt.a_in = a_gated;
    s_nxt.b_in = b_gated;
    s_nxt.wake = |(((a_sync ^ s_r.a_raw) & s_r.a_gate) |
                   ((b_sync ^ s_r.b_raw) & s_r.b_gate)); // [RULE_01] [RULE_08] [RULE_21]

    // interrupt lines, gated like the input path
    s_nxt.irq[0] = a_gated[A_IRQ_LINE_0]; // [RULE_07]
    s_nxt.irq[1] = a_gated[A_IRQ_LINE_4]; // [RULE_04]
    s_nxt.irq[2] = b_gated[B_IRQ_LINE_0]; // [RULE_11]
    s_nxt.irq[3] = b_gated[B_IRQ_LINE_5]; // [RULE_09]
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_r <= '0;
      s_r.a_gate <= A_GATE_RST;
      s_r.b_gate <= B_GATE_RST; // [RULE_08] [RULE_10]
      s_r.a_data <= DATA_RST; // [RULE_13]
      s_r.a_dir <= DIR_RST; // [RULE_14]
      s_r.a_pu <= PULL_RST;
      s_r.b_data <= DATA_RST; // [RULE_17]
      s_r.b_dir <= DIR_RST;
      s_r.b_pu <= PULL_RST; // [RULE_19]
      s_r.a_oe_n <= '1;
      s_r.b_oe_n <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign ack_o = s_r.ack;
  assign dat_o = s_r.rdat;
  assign port_a_out_o = s_r.a_out;
  assign port_a_oe_n_o = s_r.a_oe_n;
  assign port_a_pull_o = s_r.a_pull;
  assign port_b_out_o = s_r.b_out;
  assign port_b_oe_n_o = s_r.b_oe_n;
  assign port_b_pull_o = s_r.b_pull;
  assign port_a_gated_o = s_r.a_in;
  assign port_b_gated_o = s_r.b_in;
  assign pin_irq_lvl_o = s_r.irq;
  assign wake_o = s_r.wake;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_gate_a_high: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE_01]
    port_a_gated_o[7:6] == ($past(a_sync[7:6]) & $past(s_r.a_gate[7:6])))
    else $error("port a lines 7..6 gated level wrong");

  a_gate_a5: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE_03]
    !$past(s_r.a_gate[5]) |-> !port_a_gated_o[5])
    else $error("port a line 5 passes while gated");

  a_irq_a4: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE_04]
    pin_irq_lvl_o[1] == ($past(a_sync[A_IRQ_LINE_4]) && $past(s_r.a_gate[A_IRQ_LINE_4])))
    else $error("port a line 4 interrupt level wrong");

  a_gate_a3: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE_05]
    $past(s_r.a_gate[3]) && $past(a_sync[3]) |-> port_a_gated_o[3])
    else $error("port a line 3 blocked while enabled");

  a_irq_a0: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE_07]
    !$past(s_r.a_gate[A_IRQ_LINE_0]) |-> !pin_irq_lvl_o[0])
    else $error("port a line 0 interrupt while gated");

  a_gate_b_rst: assert property (@(posedge clk_i) // [RULE_10]
    $rose(nrst_i) |-> s_r.b_gate == B_GATE_RST && s_r.a_data == DATA_RST)
    else $error("gate or data reset value wrong");

  a_irq_b5: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE_09]
    pin_irq_lvl_o[3] == ($past(b_sync[B_IRQ_LINE_5]) && $past(s_r.b_gate[B_IRQ_LINE_5])))
    else $error("port b line 5 interrupt level wrong");

  a_irq_b0: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE_11]
    !$past(s_r.b_gate[B_IRQ_LINE_0]) |-> !pin_irq_lvl_o[2])
    else $error("port b line 0 interrupt while gated");

  a_od_never_high: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE_15]
    !port_a_oe_n_o[A_OD_LINE] |-> !port_a_out_o[A_OD_LINE] && $past(s_r.a_dir[A_OD_LINE]))
    else $error("open-drain line driven high or as input");

  a_dir_drive: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE_14]
    (port_a_oe_n_o | 8'h20) == (~$past(s_r.a_dir) | 8'h20))
    else $error("port a drive enable does not follow direction");

  a_pull_input: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE_16]
    (port_a_pull_o & $past(s_r.a_dir)) == '0 && (port_b_pull_o & $past(s_r.b_dir)) == '0)
    else $error("pull-up active on an output line");

  a_read_data: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE_20]
    $rose(ack_o) && $past(!we_i && idx == IDX_A_DATA) |->
      dat_o[PORT_W-1:0] == (($past(s_r.a_data) & $past(s_r.a_dir)) |
                            ($past(a_sync) & $past(s_r.a_gate) & ~$past(s_r.a_dir))))
    else $error("port a data read value wrong");

  a_wake_masked: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE_21]
    wake_o |-> |((($past(a_sync) ^ $past(a_sync, 2)) & $past(s_r.a_gate)) |
                 (($past(b_sync) ^ $past(b_sync, 2)) & $past(s_r.b_gate))))
    else $error("wake from a gated or quiet line");

  a_ack_one: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// ==== dv/pin_model.sv ====
// level model of the circuitry outside one eight-line port
`timescale 1ns/100ps
`default_nettype none
module pin_model (
  // clock
  input wire logic clk_i,
  // block side
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_n_i,
  input wire logic [7:0] pull_i,
  // outside driver set by the bench
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  // resolved pin levels
  output logic [7:0] level_o
);
  logic [7:0] float_r = 8'h00;
  // an undriven pin wanders instead of keeping its last level
  always_ff @(posedge clk_i) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n_i[i]) begin
        level_o[i] = out_i[i];
      end else if (ext_en_i[i]) begin
        level_o[i] = ext_val_i[i];
      end else if (pull_i[i]) begin
        level_o[i] = 1'b1;
      end else begin
        level_o[i] = float_r[i];
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/dual_port_gpio_block_tb.sv ====
// self-checking bench for the dual gpio port block
`timescale 1ns/100ps
`default_nettype none
module dual_port_gpio_block_tb;
  import gpio_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic ack, wake;
  logic [3:0] irq;
  logic [7:0] a_pin, a_out, a_oen, a_pull, a_gate, b_pin, b_out, b_oen, b_pull, b_gate;
  logic [7:0] a_en = 8'hff;
  logic [7:0] a_val = 8'h00;
  logic [7:0] b_en = 8'hff;
  logic [7:0] b_val = 8'h00;
  int n_fail = 0;
  int checks_done = 0;

  always #5 clk_i = ~clk_i;

  dual_port_gpio_block u_dual_port_gpio_block (.clk_i(clk_i), .nrst_i(nrst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .port_a_in_i(a_pin), .port_a_out_o(a_out), .port_a_oe_n_o(a_oen), .port_a_pull_o(a_pull),
    .port_b_in_i(b_pin), .port_b_out_o(b_out), .port_b_oe_n_o(b_oen), .port_b_pull_o(b_pull),
    .port_a_gated_o(a_gate), .port_b_gated_o(b_gate), .pin_irq_lvl_o(irq), .wake_o(wake));
  pin_model u_pin_model_a (.clk_i(clk_i), .out_i(a_out), .oe_n_i(a_oen), .pull_i(a_pull),
    .ext_en_i(a_en), .ext_val_i(a_val), .level_o(a_pin));
  pin_model u_pin_model_b (.clk_i(clk_i), .out_i(b_out), .oe_n_i(b_oen), .pull_i(b_pull),
    .ext_en_i(b_en), .ext_val_i(b_val), .level_o(b_pin));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  function automatic logic [7:0] ad(input logic [IDX_W-1:0] idx);
    return {idx, 2'b00};
  endfunction

  // entered just after an edge; ack and read data are taken at one edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      chk({31'h0, ack}, 32'h1);
      tally_and_finish();
    end
    @(posedge clk_i);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [IDX_W-1:0] idx [6];
    idx = '{IDX_A_DATA, IDX_A_DIR, IDX_A_PULL, IDX_B_DATA, IDX_B_DIR, IDX_B_PULL};
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, ad(idx[i]), 8'h00);
      chk(q, 32'h0);
    end
    chk({a_oen, b_oen, a_pull, b_pull}, 32'hffff_0000);
    a_val <= 8'hff;
    b_val <= 8'hff;
    tick(5);
    chk({16'h0, a_gate, b_gate}, 32'h0000_f9ff);
    wb(1'b1, 8'hfc, 8'hff);
    wb(1'b0, 8'hfc, 8'h00);
    chk(q, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_regs();
    logic [IDX_W-1:0] idx [4];
    idx = '{IDX_A_DIR, IDX_A_PULL, IDX_B_DIR, IDX_B_PULL};
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, ad(idx[i/2]), i[0] ? 8'ha5 : 8'h5a);
      wb(1'b0, ad(idx[i/2]), 8'h00);
      chk(q, {24'h0, i[0] ? 8'ha5 : 8'h5a});
    end
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, ad(idx[i]), 8'h00);
    end
    $display("test regs done");
  endtask

  task automatic t_drive();
    a_en <= 8'h00;
    b_en <= 8'h00;
    wb(1'b1, ad(IDX_A_DATA), 8'h7a);
    wb(1'b1, ad(IDX_B_DATA), 8'h7a);
    wb(1'b1, ad(IDX_A_DIR), 8'hff);
    wb(1'b1, ad(IDX_B_DIR), 8'hff);
    tick(2);
    chk({a_out, a_oen, b_out, b_oen}, 32'h5a20_7a00);
    wb(1'b0, ad(IDX_A_DATA), 8'h00);
    chk(q, 32'h7a);
    wb(1'b0, ad(IDX_B_DATA), 8'h00);
    chk(q, 32'h7a);
    wb(1'b1, ad(IDX_A_DATA), 8'h00);
    tick(2);
    chk({16'h0, a_out, a_oen}, 32'h0);
    wb(1'b1, ad(IDX_A_DIR), 8'h0f);
    wb(1'b1, ad(IDX_B_DIR), 8'h0f);
    wb(1'b1, ad(IDX_A_PULL), 8'hff);
    wb(1'b1, ad(IDX_B_PULL), 8'hff);
    tick(2);
    chk({16'h0, a_pull, b_pull}, 32'h0000_f0f0);
    wb(1'b1, ad(IDX_A_DIR), 8'h00);
    wb(1'b1, ad(IDX_B_DIR), 8'h00);
    wb(1'b1, ad(IDX_A_PULL), 8'h00);
    wb(1'b1, ad(IDX_B_PULL), 8'h00);
    a_en <= 8'hff;
    b_en <= 8'hff;
    $display("test drive done");
  endtask

  task automatic t_input();
    a_val <= 8'hc3;
    b_val <= 8'h3c;
    tick(4);
    wb(1'b0, ad(IDX_A_DATA), 8'h00);
    chk(q, 32'hc1);
    wb(1'b0, ad(IDX_B_DATA), 8'h00);
    chk(q, 32'h3c);
    wb(1'b1, ad(IDX_A_GATE), 8'h09);
    tick(4);
    wb(1'b0, ad(IDX_A_DATA), 8'h00);
    chk(q, 32'h01);
    chk({24'h0, a_gate}, 32'h01);
    wb(1'b1, ad(IDX_A_GATE), 8'hf9);
    $display("test input done");
  endtask

  // each line except port a lines 2..1 gated off, then gated on alone; all other pins held still
  task automatic t_wake();
    int wk;
    logic [3:0] ei;
    logic [7:0] m;
    a_val <= 8'h00;
    b_val <= 8'h00;
    tick(4);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 16; i++) begin
        if (p == 0 && (i / 2 == 1 || i / 2 == 2)) continue;
        m = 8'h01 << (i / 2);
        wb(1'b1, ad(p ? IDX_B_GATE : IDX_A_GATE), i[0] ? m : 8'h00);
        tick(4);
        wk = 0;
        if (p) b_val <= m;
        else a_val <= m;
        repeat (6) begin
          @(posedge clk_i);
          if (wake === 1'b1) wk++;
        end
        ei = {4{i[0]}} & {p && i / 2 == 5, p && i / 2 == 0, !p && i / 2 == 4, !p && i / 2 == 0};
        chk(wk, {31'h0, i[0]});
        chk({24'h0, p ? b_gate : a_gate}, i[0] ? m : 8'h00);
        chk({28'h0, irq}, {28'h0, ei});
        a_val <= 8'h00;
        b_val <= 8'h00;
        tick(6);
      end
    end
    wb(1'b1, ad(IDX_A_GATE), 8'hf9);
    wb(1'b1, ad(IDX_B_GATE), 8'hff);
    $display("test wake done");
  endtask

  initial begin
    tick(20);
    nrst_i <= 1'b1;
    tick(1);
    t_reset();
    t_regs();
    t_drive();
    t_input();
    t_wake();
    tally_and_finish();
  end
endmodule
`default_nettype wire
